// [hw/capture_timer_consts.svh]
// Notes on behaviour
// [R01] An 8-bit counter advances once per tick of the selected count clock.
// [R02] Mode input high gives capture timer; low gives plain interval timer.
// [R03] In capture mode the counter clears on the edges the clear field selects.
// [R04] A wrap with overflow interrupt enabled sets the request flag; enable gates the line.
// [R05] Software cannot read or write the counter; reset makes it zero.
// [R06] Changing the mode may raise a spurious capture event.
// [R07] A falling capture edge copies the counter into the falling capture register.
// [R08] A falling capture with edge select one sets the request flag.
// [R09] A rising capture edge copies the counter into the rising capture register.
// [R10] Both capture registers are 8-bit, read-only and reset to zero.
// [R11] Without the filter the source holds each level for two clock periods.
// [R12] A wrap while the input is high sets the overflow-high flag, bit 7.
// [R13] A wrap while low, or any wrap in interval mode, sets bit 6.
// [R14] Overflow flags are set only by hardware; writing one does nothing.
// [R15] A flag clears only when written 0 after being read as 1.
// [R16] Bit 5 enables overflow interrupt requests; it resets to 0.
// [R17] The mode register is 8 bits and resets to zero.
// [R18] In low-power modes the counter runs only on the watch-clock selection.
// [R19] A module stop bit halts this timer independently of other modules.
// [R20] Edge select 0 picks rising capture for interrupts, 1 picks falling.
// [R21] Clear field: 00 none, 01 falling, 10 rising, 11 both edges.
// [R22] Clock field: 00 div 64, 01 div 32, 10 div 2, 11 watch div 4; for 11 the code counts every watch_tick, undivided.
// [R23] The filter passes five samples and accepts a level only when all agree.
// [R24] The capture input passes two flip-flops before edge detection; the code adds a third, the registered filter output.
`ifndef CAPTURE_TIMER_CONSTS_SVH
`define CAPTURE_TIMER_CONSTS_SVH

`define OFS_TIMER_MODE      16'hffbc
`define OFS_FALL_CAPTURE    16'hffbd
`define OFS_RISE_CAPTURE    16'hffbe
`define OFS_CLOCK_STOP      16'hfffa
`define OFS_IRQ_CTRL        16'hffc0
`define RST_TIMER_MODE      8'h00
`define RST_CLOCK_STOP      8'hff
`define RST_CAPTURE         8'h00
`define BIT_OVF_HIGH        7
`define BIT_OVF_LOW         6
`define BIT_OVF_IRQ_EN      5
`define BIT_CAP_EDGE_SEL    4
`define BIT_CLK_STOP        3
`define BIT_IRQ_REQ         0
`define BIT_IRQ_EN          1
`define DIV_64              7'h3f
`define DIV_32              7'h1f
`define DIV_2               7'h01
`define FILTER_TAPS         5

`endif

// [hw/capture_timer_pkg.sv]
package capture_timer_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {CLR_NONE, CLR_FALL, CLR_RISE, CLR_BOTH} clear_sel_e;
    typedef enum logic [1:0] {CK_DIV64, CK_DIV32, CK_DIV2, CK_WATCH} clock_sel_e;
    typedef enum {BUS_IDLE, BUS_ANSWER} bus_state_e;
endpackage

// [hw/capture_filter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_consts.svh"

module capture_filter
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rstn,
    // Sampling control.
    input  wire logic sample_tick,
    input  wire logic filter_on,
    // Synchronised level in, clean level out.
    input  wire logic level_in,
    output var  logic level_out
);
    logic [`FILTER_TAPS-1:0] taps_ff;

    // Five sample latches; they only shift on the sampling tick. [R23]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            taps_ff <= '0;
        else if (sample_tick)
            taps_ff <= {taps_ff[`FILTER_TAPS-2:0], level_in};
    end

    // With the filter on, the level changes only when all taps agree, else it holds. [R23]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            level_out <= 1'b0;
        else if (!filter_on)
            level_out <= level_in;
        else if (&taps_ff)
            level_out <= 1'b1;
        else if (~|taps_ff)
            level_out <= 1'b0;
    end
endmodule
`default_nettype wire

// [hw/capture_timer.sv]
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_consts.svh"

module capture_timer
    import capture_timer_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // Avalon-MM slave.
    input  wire logic [15:0]          avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [7:0]           avs_writedata,
    output var  logic [7:0]           avs_readdata,
    output var  logic                 avs_waitrequest,
    // Pins and system controls.
    input  wire logic                 capture_input_pin,
    input  wire logic                 capture_mode_sel,
    input  wire logic                 filter_select,
    input  wire logic                 watch_tick,
    input  wire logic                 low_power_mode,
    // Interrupt request line toward the CPU.
    output var  logic                 timer_irq
);
    import capture_timer_pkg::*;

    byte_t      timer_mode_reg_ff;
    byte_t      clock_stop_reg_ff;
    byte_t      fall_capture_ff;
    byte_t      rise_capture_ff;
    byte_t      capture_counter_ff;
    logic [6:0] prescale_ff;
    logic       sync1_ff;
    logic       sync2_ff;
    logic       filt_level;
    logic       level_d_ff;
    logic       seen_high_ff;
    logic       seen_low_ff;
    logic       timer_irq_request_flag_ff;
    logic       timer_irq_enable_ff;
    bus_state_e state_ff;
    logic       count_tick;
    logic       wrap;
    logic       rise_evt;
    logic       fall_evt;
    logic       running;
    logic       wr_mode;
    logic       rd_mode;
    logic       clr_high;
    logic       clr_low;
    logic       irq_set;
    logic       irq_clr;
    clear_sel_e clear_sel;
    clock_sel_e clock_sel;
    byte_t      nxt_readdata;

    assign clear_sel = clear_sel_e'(timer_mode_reg_ff[3:2]);
    assign clock_sel = clock_sel_e'(timer_mode_reg_ff[1:0]);
    // Clearing the stop bit freezes the whole timer. [R19]
    assign running   = clock_stop_reg_ff[`BIT_CLK_STOP];

    // Free-running prescaler from the system clock.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prescale_ff <= 7'h00;
        else if (running)
            prescale_ff <= prescale_ff + 7'h01;
    end

    // Count clock selection; in low-power modes only the watch source ticks. [R22] [R18]
    always_comb
    begin
        count_tick = 1'b0;
        case (clock_sel)
            CK_DIV64: count_tick = !low_power_mode && ({1'b0, prescale_ff[5:0]} == `DIV_64);
            CK_DIV32: count_tick = !low_power_mode && ({2'h0, prescale_ff[4:0]} == `DIV_32);
            CK_DIV2:  count_tick = !low_power_mode && ({6'h00, prescale_ff[0]} == `DIV_2);
            CK_WATCH: count_tick = watch_tick;
            default:  count_tick = 1'b0;
        endcase
        count_tick = count_tick && running;
    end

    // Two-stage synchroniser on the pin before any edge logic. [R24] [R11]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= capture_input_pin;
            sync2_ff <= sync1_ff;
        end
    end

    // Optional noise filter sampled on the selected count clock.
    capture_filter u_filter
    (
        .clk        (clk),
        .rstn       (rstn),
        .sample_tick(count_tick),
        .filter_on  (filter_select),
        .level_in   (sync2_ff),
        .level_out  (filt_level)
    );

    // Capture input is gated by the mode, so a mode change can look like an edge. [R02] [R06]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            level_d_ff <= 1'b0;
        else
            level_d_ff <= filt_level && capture_mode_sel;
    end

    assign rise_evt = running && (filt_level && capture_mode_sel) && !level_d_ff;
    assign fall_evt = running && !(filt_level && capture_mode_sel) && level_d_ff;
    assign wrap     = count_tick && (capture_counter_ff == 8'hff);

    // Counter; clear on selected edges has priority over counting. [R01] [R03] [R05] [R21]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            capture_counter_ff <= 8'h00;
        else if ((rise_evt && clear_sel[1]) || (fall_evt && clear_sel[0]))
            capture_counter_ff <= 8'h00;
        else if (count_tick)
            capture_counter_ff <= capture_counter_ff + 8'h01;
    end

    // Edge captures of the current count. [R07] [R09] [R10]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fall_capture_ff <= `RST_CAPTURE;
            rise_capture_ff <= `RST_CAPTURE;
        end
        else
        begin
            if (fall_evt)
                fall_capture_ff <= capture_counter_ff;
            if (rise_evt)
                rise_capture_ff <= capture_counter_ff;
        end
    end

    // Bus decode for a taken request (one cycle after it appears).
    assign wr_mode = (state_ff == BUS_ANSWER) && avs_write && (avs_address == `OFS_TIMER_MODE);
    assign rd_mode = (state_ff == BUS_ANSWER) && avs_read && (avs_address == `OFS_TIMER_MODE);
    // A zero written clears only a flag that was read as one. [R14] [R15]
    assign clr_high = wr_mode && !avs_writedata[`BIT_OVF_HIGH] && seen_high_ff;
    assign clr_low  = wr_mode && !avs_writedata[`BIT_OVF_LOW] && seen_low_ff;

    // Read-as-one memory; it arms on the data software really saw, not on a later flag. [R15]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seen_high_ff <= 1'b0;
            seen_low_ff  <= 1'b0;
        end
        else
        begin
            if (rd_mode && avs_readdata[`BIT_OVF_HIGH])
                seen_high_ff <= 1'b1;
            else if (clr_high)
                seen_high_ff <= 1'b0;
            if (rd_mode && avs_readdata[`BIT_OVF_LOW])
                seen_low_ff <= 1'b1;
            else if (clr_low)
                seen_low_ff <= 1'b0;
        end
    end

    // Mode register: flags set by hardware win over a clear. [R12] [R13] [R16] [R17]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            timer_mode_reg_ff <= `RST_TIMER_MODE;
        else
        begin
            if (wr_mode)
                timer_mode_reg_ff[5:0] <= avs_writedata[5:0];
            if (wrap && capture_mode_sel && filt_level)
                timer_mode_reg_ff[`BIT_OVF_HIGH] <= 1'b1;
            else if (clr_high)
                timer_mode_reg_ff[`BIT_OVF_HIGH] <= 1'b0;
            if (wrap && !(capture_mode_sel && filt_level))
                timer_mode_reg_ff[`BIT_OVF_LOW] <= 1'b1;
            else if (clr_low)
                timer_mode_reg_ff[`BIT_OVF_LOW] <= 1'b0;
        end
    end

    // Module stop register; only the timer's bit acts here. [R19]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            clock_stop_reg_ff <= `RST_CLOCK_STOP;
        else if ((state_ff == BUS_ANSWER) && avs_write && (avs_address == `OFS_CLOCK_STOP))
            clock_stop_reg_ff <= avs_writedata;
    end

    // Request sources: overflow if enabled, the selected capture edge. [R04] [R08] [R20]
    assign irq_set = (wrap && timer_mode_reg_ff[`BIT_OVF_IRQ_EN])
                   || (fall_evt && timer_mode_reg_ff[`BIT_CAP_EDGE_SEL])
                   || (rise_evt && !timer_mode_reg_ff[`BIT_CAP_EDGE_SEL]);
    assign irq_clr = (state_ff == BUS_ANSWER) && avs_write && (avs_address == `OFS_IRQ_CTRL)
                   && !avs_writedata[`BIT_IRQ_REQ];

    // Request flag and enable; a new event beats a software clear. [R04] [R08]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timer_irq_request_flag_ff <= 1'b0;
            timer_irq_enable_ff       <= 1'b0;
        end
        else
        begin
            if (irq_set)
                timer_irq_request_flag_ff <= 1'b1;
            else if (irq_clr)
                timer_irq_request_flag_ff <= 1'b0;
            if ((state_ff == BUS_ANSWER) && avs_write && (avs_address == `OFS_IRQ_CTRL))
                timer_irq_enable_ff <= avs_writedata[`BIT_IRQ_EN];
        end
    end

    // The CPU line is registered from flag and enable. [R04]
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            timer_irq <= 1'b0;
        else
            timer_irq <= timer_irq_request_flag_ff && timer_irq_enable_ff;
    end

    // Read mux; the counter has no address, so it stays hidden. [R05] [R10]
    always_comb
    begin
        nxt_readdata = 8'h00;
        if (avs_address == `OFS_TIMER_MODE)
            nxt_readdata = timer_mode_reg_ff;
        else if (avs_address == `OFS_FALL_CAPTURE)
            nxt_readdata = fall_capture_ff;
        else if (avs_address == `OFS_RISE_CAPTURE)
            nxt_readdata = rise_capture_ff;
        else if (avs_address == `OFS_CLOCK_STOP)
            nxt_readdata = clock_stop_reg_ff;
        else if (avs_address == `OFS_IRQ_CTRL)
            nxt_readdata = {6'h00, timer_irq_enable_ff, timer_irq_request_flag_ff};
    end

    // One wait cycle per access keeps read data and waitrequest registered.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff        <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 8'h00;
        end
        else
        begin
            case (state_ff)
                BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        state_ff        <= BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= nxt_readdata;
                    end
                    else
                        avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    state_ff        <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Checks.
    property p_wrap_clears;
        @(posedge clk) disable iff (!rstn) wrap && !(rise_evt || fall_evt) |=> capture_counter_ff == 8'h00;
    endproperty
    a_wrap_clears: assert property (p_wrap_clears) else $error("counter did not wrap"); // [R01]

    property p_clear_fall;
        @(posedge clk) disable iff (!rstn) fall_evt && clear_sel[0] |=> capture_counter_ff == 8'h00;
    endproperty
    a_clear_fall: assert property (p_clear_fall) else $error("falling clear missed"); // [R03]

    property p_fall_cap;
        @(posedge clk) disable iff (!rstn) fall_evt |=> fall_capture_ff == $past(capture_counter_ff);
    endproperty
    a_fall_cap: assert property (p_fall_cap) else $error("falling capture wrong"); // [R07]

    property p_rise_cap;
        @(posedge clk) disable iff (!rstn) rise_evt |=> rise_capture_ff == $past(capture_counter_ff);
    endproperty
    a_rise_cap: assert property (p_rise_cap) else $error("rising capture wrong"); // [R09]

    property p_ovf_low;
        @(posedge clk) disable iff (!rstn) wrap && !capture_mode_sel |=> timer_mode_reg_ff[6];
    endproperty
    a_ovf_low: assert property (p_ovf_low) else $error("low overflow flag not set"); // [R13]

    property p_ovf_high;
        @(posedge clk) disable iff (!rstn) wrap && capture_mode_sel && filt_level |=> timer_mode_reg_ff[7];
    endproperty
    a_ovf_high: assert property (p_ovf_high) else $error("high overflow flag not set"); // [R12]

    property p_no_sw_set;
        @(posedge clk) disable iff (!rstn) !timer_mode_reg_ff[7] && !wrap |=> !timer_mode_reg_ff[7];
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without overflow"); // [R14]

    property p_irq_out;
        @(posedge clk) disable iff (!rstn) irq_set && timer_irq_enable_ff ##1 timer_irq_enable_ff |=> timer_irq;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("interrupt line not raised"); // [R04]

    property p_stopped;
        @(posedge clk) disable iff (!rstn) !running |=> $stable(capture_counter_ff);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped"); // [R19]

    property p_overflow_irq_enable_rst;
        @(posedge clk) disable iff (!rstn) $rose(rstn) |-> !timer_mode_reg_ff[5];
    endproperty
    a_overflow_irq_enable_rst: assert property (p_overflow_irq_enable_rst) else $error("enable not zero at reset"); // [R16]

    c_wrap:  cover property (@(posedge clk) disable iff (!rstn) wrap);
    c_rise:  cover property (@(posedge clk) disable iff (!rstn) rise_evt);
    c_fall:  cover property (@(posedge clk) disable iff (!rstn) fall_evt);
    c_clear: cover property (@(posedge clk) disable iff (!rstn) clr_low);
endmodule
`default_nettype wire

// [sim/pulse_source.sv]
`timescale 1ns/1ps
`default_nettype none

// Behavioural pulse source on the capture pin; the pin idles low between pulses.
module pulse_source
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rstn,
    // Pulse request and shape in clock cycles.
    input  wire logic       go,
    input  wire logic [9:0] high_len,
    input  wire logic [9:0] low_len,
    // Pin level and status.
    output var  logic       pin,
    output var  logic       busy
);
    logic [9:0] cnt_ff;
    logic [9:0] hi_n;
    logic [9:0] lo_n;

    // Levels shorter than two cycles may be lost by the sampler, so stretch them.
    assign hi_n = (high_len < 10'd2) ? 10'd2 : high_len;
    assign lo_n = (low_len < 10'd2) ? 10'd2 : low_len;

    // High phase, then low phase, then idle; a new request is taken only when idle.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff <= '0;
            pin    <= 1'b0;
            busy   <= 1'b0;
        end
        else if (!busy)
        begin
            if (go)
            begin
                busy   <= 1'b1;
                pin    <= 1'b1;
                cnt_ff <= hi_n - 10'd1;
            end
        end
        else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - 10'd1;
        else if (pin)
        begin
            pin    <= 1'b0;
            cnt_ff <= lo_n - 10'd1;
        end
        else
            busy <= 1'b0;
    end
endmodule

`default_nettype wire

// [sim/capture_interval_timer_8bit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_consts.svh"

module capture_interval_timer_8bit_tb;
    import capture_timer_pkg::*;

    logic        clk;
    logic        rstn;
    logic [15:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [7:0]  avs_writedata;
    logic [7:0]  avs_readdata;
    logic        avs_waitrequest;
    logic        capture_mode_sel;
    logic        low_power_mode;
    logic        filter_en;
    logic        watch_tick;
    logic        timer_irq;
    logic        pin;
    logic        busy;
    logic        go;
    logic [9:0]  high_len;
    logic [9:0]  low_len;
    logic [1:0]  wdiv_ff;
    int          failures;
    int          checks;
    byte_t       r;
    byte_t       f;
    // Clock rows: clock field, low power, high cycles, expected capture spacing.
    int          cks [5] = '{2, 1, 0, 3, 2};
    int          lpm [5] = '{0, 0, 0, 1, 1};
    int          hln [5] = '{40, 64, 128, 40, 40};
    int          dlt [5] = '{20, 2, 2, 10, 0};

    // System clock at 40 MHz.
    always #12.5 clk = ~clk;

    // Watch tick on every fourth cycle stands in for the slow watch clock.
    always @(posedge clk)
    begin
        wdiv_ff    <= wdiv_ff + 2'd1;
        watch_tick <= (wdiv_ff == 2'd3);
    end

    capture_timer u_capture_timer
    (
        .clk               (clk),
        .rstn              (rstn),
        .avs_address       (avs_address),
        .avs_read          (avs_read),
        .avs_write         (avs_write),
        .avs_writedata     (avs_writedata),
        .avs_readdata      (avs_readdata),
        .avs_waitrequest   (avs_waitrequest),
        .capture_input_pin (pin),
        .capture_mode_sel  (capture_mode_sel),
        .filter_select     (filter_en),
        .watch_tick        (watch_tick),
        .low_power_mode    (low_power_mode),
        .timer_irq         (timer_irq)
    );

    pulse_source u_pulse_source
    (
        .clk      (clk),
        .rstn     (rstn),
        .go       (go),
        .high_len (high_len),
        .low_len  (low_len),
        .pin      (pin),
        .busy     (busy)
    );

    task automatic chk(input byte_t got, input byte_t exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input byte_t got, input byte_t lo, input byte_t hi);
        checks++;
        if (((got >= lo) && (got <= hi)) !== 1'b1)
        begin
            failures++;
            $display("[ERR] %0t got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask

    // One bus cycle; the request holds until waitrequest is seen low at an edge.
    task automatic bus(input logic wr, input logic [15:0] a, input byte_t d, output byte_t q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        if (n >= 64)
        begin
            failures++;
            $display("[ERR] %0t bus answer missing", $time);
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input byte_t d);
        byte_t q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [15:0] a, output byte_t q);
        bus(1'b0, a, 8'h00, q);
    endtask

    task automatic start_pulse(input int h, input int l);
        high_len <= h[9:0];
        low_len  <= l[9:0];
        go       <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (busy !== 1'b0 && n < 2000);
        if (n >= 2000)
        begin
            failures++;
            $display("[ERR] %0t pulse source stuck", $time);
        end
    endtask

    task automatic pulse(input int h, input int l);
        start_pulse(h, l);
        wait_idle();
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // A hang is cut short well after the expected few thousand cycles.
    initial
    begin
        #500_000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    // Main sequence; interval mode first so the overflow happens from a known count.
    initial
    begin
        {clk, rstn, avs_read, avs_write, go, low_power_mode, capture_mode_sel, filter_en} = '0;
        {avs_address, avs_writedata, high_len, low_len, wdiv_ff, watch_tick} = '0;
        failures = 0;
        checks   = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(`OFS_TIMER_MODE, r); chk(r, `RST_TIMER_MODE);
        rd(`OFS_FALL_CAPTURE, r); chk(r, `RST_CAPTURE);
        rd(`OFS_RISE_CAPTURE, r); chk(r, `RST_CAPTURE);
        rd(`OFS_CLOCK_STOP, r); chk(r, `RST_CLOCK_STOP);
        wr(`OFS_FALL_CAPTURE, 8'hff); rd(`OFS_FALL_CAPTURE, r); chk(r, 8'h00);
        rd(16'h0000, r); chk(r, 8'h00);
        wr(`OFS_TIMER_MODE, 8'hff); rd(`OFS_TIMER_MODE, r); chk(r, 8'h3f);
        $display("test reset done");
        // Interval overflow at divide by 2 with overflow requests enabled.
        wr(`OFS_TIMER_MODE, 8'h22);
        repeat (600) @(posedge clk);
        wr(`OFS_TIMER_MODE, 8'h20); rd(`OFS_TIMER_MODE, r); chk(r, 8'h60);
        wr(`OFS_TIMER_MODE, 8'h20); rd(`OFS_TIMER_MODE, r); chk(r, 8'h20);
        rd(`OFS_IRQ_CTRL, r); chk(r, 8'h01);
        chk({7'h00, timer_irq}, 8'h00);
        wr(`OFS_IRQ_CTRL, 8'h03); repeat (3) @(posedge clk);
        chk({7'h00, timer_irq}, 8'h01);
        wr(`OFS_IRQ_CTRL, 8'h00); repeat (3) @(posedge clk);
        chk({7'h00, timer_irq}, 8'h00);
        $display("test interval overflow done");
        // Capture mode, pin held high across a wrap.
        capture_mode_sel <= 1'b1;
        wr(`OFS_TIMER_MODE, 8'h02);
        pulse(700, 4);
        rd(`OFS_TIMER_MODE, r); chk(r & 8'h80, 8'h80);
        wr(`OFS_TIMER_MODE, 8'h02); rd(`OFS_TIMER_MODE, r); chk(r & 8'hc0, 8'h00);
        $display("test overflow high done");
        // Capture spacing per clock selection and low-power setting.
        for (int i = 0; i < 5; i++)
        begin
            low_power_mode <= lpm[i][0];
            wr(`OFS_TIMER_MODE, byte_t'(cks[i]));
            pulse(hln[i], 8);
            rd(`OFS_RISE_CAPTURE, r);
            rd(`OFS_FALL_CAPTURE, f);
            chk(f - r, byte_t'(dlt[i]));
        end
        low_power_mode <= 1'b0;
        $display("test clock select done");
        // Clear field; the low level between pulses lasts 32 cycles, the second high 6.
        for (int c = 0; c < 4; c++)
        begin
            wr(`OFS_TIMER_MODE, byte_t'(c * 4 + 2));
            pulse(30, 30);
            pulse(6, 6);
            rd(`OFS_RISE_CAPTURE, r);
            rd(`OFS_FALL_CAPTURE, f);
            if (c[1]) chk_rng(f, 8'h02, 8'h04); else chk(f - r, 8'h03);
            if (c[0]) chk_rng(r, 8'h0f, 8'h11);
        end
        $display("test counter clear done");
        // Edge select picks which capture edge raises the request flag.
        for (int s = 0; s < 2; s++)
        begin
            wr(`OFS_TIMER_MODE, byte_t'(s * 16 + 2));
            wr(`OFS_IRQ_CTRL, 8'h00);
            start_pulse(40, 8);
            repeat (12) @(posedge clk);
            rd(`OFS_IRQ_CTRL, r); chk(r, byte_t'(1 - s));
            wr(`OFS_IRQ_CTRL, 8'h00);
            wait_idle();
            rd(`OFS_IRQ_CTRL, r); chk(r, byte_t'(s));
        end
        $display("test edge select done");
        // Noise filter on: a 4-cycle pulse never fills the taps, a 40-cycle one does.
        filter_en <= 1'b1;
        wr(`OFS_TIMER_MODE, 8'h02);
        wr(`OFS_IRQ_CTRL, 8'h00);
        pulse(4, 40);
        rd(`OFS_IRQ_CTRL, r); chk(r, 8'h00);
        pulse(40, 40);
        rd(`OFS_IRQ_CTRL, r); chk(r, 8'h01);
        filter_en <= 1'b0;
        $display("test noise filter done");
        // Module stop freezes captures.
        wr(`OFS_CLOCK_STOP, 8'hf7); rd(`OFS_CLOCK_STOP, r); chk(r, 8'hf7);
        rd(`OFS_RISE_CAPTURE, f);
        pulse(40, 8);
        rd(`OFS_RISE_CAPTURE, r); chk(r, f);
        wr(`OFS_CLOCK_STOP, 8'hff);
        $display("test module stop done");
        print_verdict();
    end
endmodule

`default_nettype wire
